// [core/ttc_pkg.sv]
// Purpose: constants, field layouts and types of the dual timer/event counter
// Assumes: 200 MHz system clock, APB register access, byte address = index * 4
// Notes: How it works list below; both counters share one control layout
//
// How it works
// RULE1: counter 1 prescale 1,2,4,8, else 16
// RULE2: event mode edge bit picks falling or rising
// RULE3: pulse mode edge bit picks start/stop edges
// RULE4: enable bit gates counter 1 counting
// RULE5: source bit picks fsys (counter 0) or fsys/4 (counter 1), or RC oscillator
// RULE6: mode field: event, timer, pulse, unused
// RULE7: pulse mode overflow reloads and requests interrupt
// RULE8: pulse mode end clears enable by hardware
// RULE9: event/timer modes: only software clears enable
// RULE10: any overflow is a wake-up source
// RULE11: cleared interrupt enable blocks interrupt request
// RULE12: disabled counter: write loads counter too
// RULE13: enabled counter: write loads preload only
// RULE14: counter read blocks its counting clock
// RULE15: software loads start value before enabling
// RULE16: count up to all ones, reload, flag
// RULE17: pulse result held until enable set again
// RULE18: low byte buffered, high write transfers both
// RULE19: high read latches low byte into buffer
// RULE20: mode 00 holds value, no overflow
package ttc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_INTC = 6'h0B;
    localparam logic [5:0] IDX_C0_VALUE = 6'h0D;
    localparam logic [5:0] IDX_C0_CTRL = 6'h0E;
    localparam logic [5:0] IDX_C1_HIGH = 6'h0F;
    localparam logic [5:0] IDX_C1_LOW = 6'h10;
    localparam logic [5:0] IDX_C1_CTRL = 6'h11;
    // interrupt control register bit positions
    localparam int C0_IRQ_EN_BIT = 1;
    localparam int C1_IRQ_EN_BIT = 2;
    localparam int C0_FLAG_BIT = 5;
    localparam int C1_FLAG_BIT = 6;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // widest prescale code honoured per counter
    localparam logic [2:0] C0_MAX_CODE = 3'h6;
    localparam logic [2:0] C1_MAX_CODE = 3'h4;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int FSYS4_DIV = 4;
    // counter widths
    localparam int C0_WIDTH = 8;
    localparam int C1_WIDTH = 16;

    typedef enum logic [1:0] {
        MODE_UNUSED = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } ttc_mode_type;

    // pulse width measurement progress
    typedef enum logic [1:0] {
        PW_WAIT = 2'b00,
        PW_MEASURE = 2'b01
    } ttc_pw_type;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        ttc_mode_type mode;
        logic clock_source_sel;
        logic count_enable;
        logic edge_select;
        logic [2:0] prescale_sel;
    } ttc_ctrl_type;

    // one synchronised pin: stable level and its edges
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } ttc_pin_type;
endpackage

// [core/ttc_pin_sync.sv]
// Purpose: three flip-flop synchroniser with agreement filter and edge pulses
// Assumes: pin is asynchronous to clk_in
// Notes: a change counts only when the second and third stages agree
`timescale 1ns/100ps
module ttc_pin_sync (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic pin_in,
    output ttc_pkg::ttc_pin_type pin_out
);
    logic s1; // first stage, read only by s2
    logic s2;
    logic s3;
    logic level; // filtered level

    // shift chain, frozen with the clock enable
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else if (ce_in)
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accept a new level only once two stages agree
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            level <= 1'b0;
        else if (ce_in && (s2 == s3))
            level <= s3;
    end

    // edge pulses last the cycle before the level updates
    always_comb
    begin
        pin_out.level = level;
        pin_out.rise = ce_in && (s2 == s3) && s3 && !level;
        pin_out.fall = ce_in && (s2 == s3) && !s3 && level;
    end
endmodule

// [core/ttc_prescale.sv]
// Purpose: power of two prescaler on a tick stream
// Assumes: tick_in is one cycle wide
// Notes: codes above MAX_CODE divide as MAX_CODE does
`timescale 1ns/100ps
module ttc_prescale #(
    parameter logic [2:0] MAX_CODE = 3'h4
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic tick_in,
    input wire logic [2:0] sel_in,
    output logic tick_out
);
    logic [5:0] stage; // ripple stages, 64 at most

    // mask of low stages that must be all ones
    function automatic logic [5:0] stage_mask(input logic [2:0] code);
        logic [2:0] eff;
        eff = (code > MAX_CODE) ? MAX_CODE : code;
        stage_mask = 6'((7'h01 << eff) - 7'h01);
    endfunction

    // advance on every source tick
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            stage <= 6'h00;
        else if (ce_in && tick_in)
            stage <= 6'(stage + 6'h01);
    end

    // RULE1: divide by 1, 2, 4, 8 or 16 at the default MAX_CODE, up to 64 for counter 0
    assign tick_out = ce_in && tick_in &&
        ((stage & stage_mask(sel_in)) == stage_mask(sel_in));
endmodule

// [core/ttc_timer_top.sv]
// Purpose: two count-up timer/event counters behind an APB slave
// Assumes: pins and RC oscillator are asynchronous; ce_in freezes all state
// Notes: counter 0 is 8 bits, counter 1 is 16 bits with a low-byte buffer
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module ttc_timer_top #(
    parameter int C0_W = ttc_pkg::C0_WIDTH,
    parameter int C1_W = ttc_pkg::C1_WIDTH
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic counter0_value_or_pin_in,
    input wire logic counter1_value_or_pin_in,
    input wire logic rc_osc_in,
    output logic c0_irq_req_out,
    output logic c1_irq_req_out,
    output logic wake_out
);
    // per-counter state, counter 0 uses the low bits only
    ttc_pkg::ttc_ctrl_type ctrl [2];
    logic [15:0] count [2];
    logic [15:0] preload [2];
    ttc_pkg::ttc_pw_type pw_state [2];
    logic [7:0] low_buf; // counter 1 low byte buffer
    logic [7:0] intc; // interrupt enables and overflow flags
    logic [1:0] fsys4_div; // system clock divided by four
    logic [1:0] irq_req;
    // combinational per-counter signals
    logic [1:0] src_tick;
    logic [1:0] int_tick;
    logic [1:0] cnt_tick;
    logic [1:0] ovf;
    logic [1:0] pw_done;
    logic [1:0] rd_blk;
    logic [1:0] wr_val;
    logic [1:0] wr_ctrl;
    logic [15:0] wr_data [2];
    ttc_pkg::ttc_pin_type pin [2];
    ttc_pkg::ttc_pin_type rc;
    // bus decode
    logic [5:0] idx;
    logic hit;
    logic setup;
    logic access;
    logic wr_evt;
    logic rd_evt;
    logic fsys4_tick;

    // address decode, shared by setup and access phases
    function automatic logic mapped(input logic [7:0] a);
        logic [5:0] i;
        i = a[7:2];
        mapped = (a[1:0] == 2'b00) && (i == ttc_pkg::IDX_INTC ||
            i == ttc_pkg::IDX_C0_VALUE || i == ttc_pkg::IDX_C0_CTRL ||
            i == ttc_pkg::IDX_C1_HIGH || i == ttc_pkg::IDX_C1_LOW ||
            i == ttc_pkg::IDX_C1_CTRL);
    endfunction

    assign idx = paddr_in[7:2];
    assign hit = mapped(paddr_in);
    assign setup = psel_in && !penable_in;
    assign access = psel_in && penable_in && pready_out;
    // errored transfers store nothing and read nothing
    assign wr_evt = ce_in && access && pwrite_in && !pslverr_out;
    assign rd_evt = ce_in && access && !pwrite_in && !pslverr_out;

    // pin synchronisers, one per counter pin plus the RC oscillator
    ttc_pin_sync u_c0_pin (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .pin_in(counter0_value_or_pin_in),
        .pin_out(pin[0])
    );
    ttc_pin_sync u_c1_pin (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .pin_in(counter1_value_or_pin_in),
        .pin_out(pin[1])
    );
    ttc_pin_sync u_rc_pin (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .pin_in(rc_osc_in),
        .pin_out(rc)
    );

    // divide-by-four base for counter 1
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            fsys4_div <= 2'h0;
        else if (ce_in)
            fsys4_div <= 2'(fsys4_div + 2'h1);
    end
    assign fsys4_tick = ce_in && (fsys4_div == 2'(ttc_pkg::FSYS4_DIV - 1));

    // RULE5: internal clock source selection
    assign src_tick[0] = ce_in && (ctrl[0].clock_source_sel ? rc.rise : 1'b1);
    assign src_tick[1] = ce_in && (ctrl[1].clock_source_sel ? rc.rise : fsys4_tick);

    ttc_prescale #(.MAX_CODE(ttc_pkg::C0_MAX_CODE)) u_c0_pre (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .tick_in(src_tick[0]),
        .sel_in(ctrl[0].prescale_sel),
        .tick_out(int_tick[0])
    );
    // RULE1: counter 1 prescaler capped at divide by sixteen
    ttc_prescale #(.MAX_CODE(ttc_pkg::C1_MAX_CODE)) u_c1_pre (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .tick_in(src_tick[1]),
        .sel_in(ctrl[1].prescale_sel),
        .tick_out(int_tick[1])
    );

    // write strobes and data per counter
    always_comb
    begin
        wr_val[0] = wr_evt && (idx == ttc_pkg::IDX_C0_VALUE);
        wr_ctrl[0] = wr_evt && (idx == ttc_pkg::IDX_C0_CTRL);
        wr_data[0] = {8'h00, pwdata_in[7:0]};
        // RULE18: high write carries the buffered low byte
        wr_val[1] = wr_evt && (idx == ttc_pkg::IDX_C1_HIGH);
        wr_ctrl[1] = wr_evt && (idx == ttc_pkg::IDX_C1_CTRL);
        wr_data[1] = {pwdata_in[7:0], low_buf};
        // RULE14: any read of a counter, setup to access, stalls it
        rd_blk[0] = psel_in && !pwrite_in && (idx == ttc_pkg::IDX_C0_VALUE);
        rd_blk[1] = psel_in && !pwrite_in &&
            (idx == ttc_pkg::IDX_C1_HIGH || idx == ttc_pkg::IDX_C1_LOW);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cnt
            localparam int W = (gi == 0) ? C0_W : C1_W;
            localparam logic [15:0] TOP = 16'((17'h0_0001 << W) - 17'h0_0001);
            localparam int FLAG = (gi == 0) ? ttc_pkg::C0_FLAG_BIT : ttc_pkg::C1_FLAG_BIT;
            localparam int IEN = (gi == 0) ? ttc_pkg::C0_IRQ_EN_BIT : ttc_pkg::C1_IRQ_EN_BIT;
            logic start_edge;
            logic stop_edge;
            logic ev_tick;

            // RULE2: event edge; RULE3: pulse start and stop edges
            assign ev_tick = ctrl[gi].edge_select ? pin[gi].fall : pin[gi].rise;
            assign start_edge = ctrl[gi].edge_select ? pin[gi].rise : pin[gi].fall;
            assign stop_edge = ctrl[gi].edge_select ? pin[gi].fall : pin[gi].rise;

            // count tick selection by mode
            always_comb
            begin
                cnt_tick[gi] = 1'b0;
                // RULE4: enable gates; RULE14: reads stall
                if (ce_in && ctrl[gi].count_enable && !rd_blk[gi])
                begin
                    // RULE6: mode decode; RULE20: unused mode never ticks
                    case (ctrl[gi].mode)
                        ttc_pkg::MODE_EVENT: cnt_tick[gi] = ev_tick;
                        ttc_pkg::MODE_TIMER: cnt_tick[gi] = int_tick[gi];
                        ttc_pkg::MODE_PULSE:
                            cnt_tick[gi] = int_tick[gi] && (pw_state[gi] == ttc_pkg::PW_MEASURE);
                        default: cnt_tick[gi] = 1'b0;
                    endcase
                end
            end
            // RULE16: overflow at all ones
            assign ovf[gi] = cnt_tick[gi] && (count[gi] == TOP);
            assign pw_done[gi] = ce_in && ctrl[gi].count_enable &&
                (ctrl[gi].mode == ttc_pkg::MODE_PULSE) &&
                (pw_state[gi] == ttc_pkg::PW_MEASURE) && stop_edge;

            // pulse measurement sequencer, idle unless enabled in pulse mode
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    pw_state[gi] <= ttc_pkg::PW_WAIT;
                else if (ce_in)
                begin
                    if (!ctrl[gi].count_enable || ctrl[gi].mode != ttc_pkg::MODE_PULSE)
                        pw_state[gi] <= ttc_pkg::PW_WAIT;
                    else
                    begin
                        case (pw_state[gi])
                            ttc_pkg::PW_WAIT:
                                if (start_edge)
                                    pw_state[gi] <= ttc_pkg::PW_MEASURE;
                            ttc_pkg::PW_MEASURE:
                                if (stop_edge)
                                    pw_state[gi] <= ttc_pkg::PW_WAIT;
                            default: pw_state[gi] <= ttc_pkg::PW_WAIT;
                        endcase
                    end
                end
            end

            // control register; a software write wins over the hardware clear
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    ctrl[gi] <= ttc_pkg::CTRL_RESET;
                else if (wr_ctrl[gi])
                    ctrl[gi] <= pwdata_in[7:0];
                // RULE8: end of measurement drops enable; RULE17: result held
                // RULE9: only pulse mode reaches this clear
                else if (pw_done[gi])
                    ctrl[gi].count_enable <= 1'b0;
            end

            // preload takes every value write
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    preload[gi] <= ttc_pkg::COUNT_RESET;
                else if (wr_val[gi])
                    preload[gi] <= wr_data[gi] & TOP;
            end

            // the counter itself
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    count[gi] <= ttc_pkg::COUNT_RESET;
                // RULE16: reload on overflow; RULE7: pulse mode too
                else if (ovf[gi])
                    count[gi] <= preload[gi];
                // RULE12: stopped counter is loaded directly
                // RULE13: running counter keeps going
                else if (wr_val[gi] && !ctrl[gi].count_enable)
                    count[gi] <= wr_data[gi] & TOP;
                else if (cnt_tick[gi])
                    count[gi] <= 16'(count[gi] + 16'h0001) & TOP;
            end

            // registered request: flag gated by its enable
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                    irq_req[gi] <= 1'b0;
                // RULE11: disabled interrupt never requests
                else if (ce_in)
                    irq_req[gi] <= intc[FLAG] && intc[IEN];
            end

            a_ovf_reload: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE16
                ovf[gi] |=> count[gi] == $past(preload[gi]))
                else $error("counter did not reload from preload on overflow");
            a_ovf_flag: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE7
                ovf[gi] |=> intc[FLAG] ##1 (irq_req[gi] == intc[IEN] || !ce_in))
                else $error("overflow flag or request missing");
            a_pulse_clear: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE8
                pw_done[gi] && !wr_ctrl[gi] |=> !ctrl[gi].count_enable)
                else $error("pulse measurement did not clear enable");
            a_enable_kept: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE9
                ctrl[gi].count_enable && ctrl[gi].mode != ttc_pkg::MODE_PULSE
                && !wr_ctrl[gi] |=> ctrl[gi].count_enable)
                else $error("enable cleared outside pulse mode");
            a_unused_hold: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE20
                ctrl[gi].mode == ttc_pkg::MODE_UNUSED && !wr_val[gi] |=> $stable(count[gi]))
                else $error("counter moved in unused mode");
            a_read_block: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE14
                rd_blk[gi] && !wr_val[gi] |=> $stable(count[gi]))
                else $error("counter moved during a read");
            a_irq_gate: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE11
                !intc[IEN] |=> !irq_req[gi])
                else $error("request raised with interrupt disabled");
            a_stopped_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE12
                wr_val[gi] && !ctrl[gi].count_enable |=> count[gi] == preload[gi])
                else $error("stopped counter not loaded by write");
            a_running_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE13
                wr_val[gi] && ctrl[gi].count_enable && !ovf[gi] && !cnt_tick[gi]
                |=> $stable(count[gi]))
                else $error("running counter overwritten by write");
        end
    endgenerate

    // interrupt control register; overflow set wins over a software clear
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            intc <= 8'h00;
        else if (ce_in)
        begin
            if (wr_evt && idx == ttc_pkg::IDX_INTC)
                intc <= pwdata_in[7:0];
            if (ovf[0])
                intc[ttc_pkg::C0_FLAG_BIT] <= 1'b1;
            if (ovf[1])
                intc[ttc_pkg::C1_FLAG_BIT] <= 1'b1;
        end
    end

    // low byte buffer of counter 1
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            low_buf <= 8'h00;
        // RULE18: low write lands only here
        else if (wr_evt && idx == ttc_pkg::IDX_C1_LOW)
            low_buf <= pwdata_in[7:0];
        // RULE19: high read snapshots the low byte
        else if (rd_evt && idx == ttc_pkg::IDX_C1_HIGH)
            low_buf <= count[1][7:0];
    end

    // RULE10: one-cycle wake-up pulse on any overflow
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            wake_out <= 1'b0;
        else if (ce_in)
            wake_out <= |ovf;
    end

    // APB answer: ready in the first access cycle, data sampled at setup
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            pready_out <= setup;
            pslverr_out <= setup && !hit;
            if (setup && !pwrite_in)
            begin
                case (idx)
                    ttc_pkg::IDX_INTC: prdata_out <= {24'h00_0000, intc};
                    ttc_pkg::IDX_C0_VALUE: prdata_out <= {24'h00_0000, count[0][7:0]};
                    ttc_pkg::IDX_C0_CTRL: prdata_out <= {24'h00_0000, ctrl[0]};
                    ttc_pkg::IDX_C1_HIGH: prdata_out <= {24'h00_0000, count[1][15:8]};
                    // RULE19: low read returns the buffer
                    ttc_pkg::IDX_C1_LOW: prdata_out <= {24'h00_0000, low_buf};
                    ttc_pkg::IDX_C1_CTRL: prdata_out <= {24'h00_0000, ctrl[1]};
                    default: prdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign c0_irq_req_out = irq_req[0];
    assign c1_irq_req_out = irq_req[1];

    a_pready_next: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && setup |=> pready_out)
        else $error("no ready in first access cycle");
    a_wake_ovf: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE10
        ce_in && (ovf != 2'b00) |=> wake_out)
        else $error("overflow gave no wake-up pulse");
    a_low_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE18
        wr_evt && idx == ttc_pkg::IDX_C1_LOW
        |=> $stable(preload[1]) && low_buf == $past(pwdata_in[7:0]))
        else $error("low byte write did not stay in buffer");
endmodule

// [tb/ttc_pin_model.sv]
// Purpose: far-side model of the two event pins and the rc oscillator
// Assumes: pins idle low; each level is held far longer than three clocks
// Notes: rc oscillator runs free at eight system clocks, never on a rising clock edge
`timescale 1ns/100ps
module ttc_pin_model (
    input wire logic clk_in,
    output logic c0_pin_out,
    output logic c1_pin_out,
    output logic rc_osc_out
);
    logic [1:0] lvl = 2'b00; // pin levels, index is counter number
    assign c0_pin_out = lvl[0];
    assign c1_pin_out = lvl[1];
    // free running oscillator, offset so it never meets a rising edge
    initial
    begin
        rc_osc_out = 1'b0;
        forever #20 rc_osc_out = ~rc_osc_out;
    end
    // one high-then-low pulse; short levels would be lost in the sync
    task automatic pulse(input int idx, input int len);
        @(posedge clk_in);
        lvl[idx] <= 1'b1;
        repeat (len) @(posedge clk_in);
        lvl[idx] <= 1'b0;
        repeat (len) @(posedge clk_in);
    endtask
endmodule

// [tb/dual_timer_event_counter_tb_top.sv]
// Purpose: self-checking bench for the dual timer/event counter
// Assumes: apb slave answers in its own time; counter 1 counts read once stopped
// Notes: timed counts are checked in a small window, since sync lags vary
`timescale 1ns/100ps
module dual_timer_event_counter_tb_top;
    localparam logic [5:0] INTC = ttc_pkg::IDX_INTC;
    localparam logic [5:0] C0V = ttc_pkg::IDX_C0_VALUE;
    localparam logic [5:0] C0C = ttc_pkg::IDX_C0_CTRL;
    localparam logic [5:0] HI = ttc_pkg::IDX_C1_HIGH;
    localparam logic [5:0] LO = ttc_pkg::IDX_C1_LOW;
    localparam logic [5:0] C1C = ttc_pkg::IDX_C1_CTRL;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ce = 1'b1; // clock enable, dropped to freeze the block
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, c0_pin, c1_pin, rc_osc, c0_irq, c1_irq, wake;
    logic [15:0] cnt, m_c1; // last count read, model of counter 1
    logic [7:0] m_c0, m_pre; // model of counter 0 and its preload
    int errors = 0;
    int tests_run = 0;
    int wakes = 0;
    always #2.5 clk_in = ~clk_in;
    ttc_timer_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .counter0_value_or_pin_in(c0_pin), .counter1_value_or_pin_in(c1_pin),
        .rc_osc_in(rc_osc), .c0_irq_req_out(c0_irq), .c1_irq_req_out(c1_irq),
        .wake_out(wake));
    ttc_pin_model pm (.clk_in(clk_in), .c0_pin_out(c0_pin), .c1_pin_out(c1_pin),
        .rc_osc_out(rc_osc));
    // tally wake pulses seen
    always @(posedge clk_in)
        if (wake === 1'b1) wakes <= wakes + 1;
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        // a slave that never answers ends the run here
        if (n >= 50)
        begin
            chk("pready", 1, 0);
            finish_test();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp, input string name);
        apb(1'b0, idx, 8'h00);
        chk(name, exp, rd);
    endtask
    // stop counter 1, load zero first, then start it with ctrl
    task automatic start1(input logic [7:0] ctrl);
        apb(1'b1, C1C, 8'h00);
        apb(1'b1, LO, 8'h00);
        apb(1'b1, HI, 8'h00);
        apb(1'b1, C1C, ctrl);
    endtask
    // read the 16-bit count as a pair and check it within two
    task automatic win(input logic [15:0] exp, input string name);
        apb(1'b0, HI, 8'h00);
        cnt[15:8] = rd[7:0];
        apb(1'b0, LO, 8'h00);
        cnt[7:0] = rd[7:0];
        chk(name, exp, (cnt + 16'd3 > exp && cnt < exp + 16'd3) ? exp : cnt);
    endtask
    task automatic run_timer(input logic [7:0] ctrl, input logic [15:0] exp);
        start1(ctrl);
        repeat (320) @(posedge clk_in);
        // a frozen block must not count, so the expectation is unchanged
        ce <= 1'b0;
        repeat (100) @(posedge clk_in);
        ce <= 1'b1;
        repeat (320) @(posedge clk_in);
        apb(1'b1, C1C, ctrl & 8'hEF);
        win(exp, "timer count");
    endtask
    // counter 0 model steps on each pin pulse
    task automatic step0();
        pm.pulse(0, 8);
        m_c0 = (m_c0 == 8'hFF) ? m_pre : m_c0 + 8'h01;
    endtask
    initial
    begin
        #(40000 * 5);
        errors++;
        finish_test();
    end
    initial
    begin
        m_c1 = $urandom(32'hb5f1_d43a);
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        rdchk(C1C, 0, "c1 ctrl reset");
        apb(1'b0, 6'h3F, 8'h00);
        chk("unmapped err", 1, err);
        m_c1 = $urandom();
        apb(1'b1, LO, m_c1[7:0]);
        apb(1'b1, HI, m_c1[15:8]);
        rdchk(HI, m_c1[15:8], "c1 high");
        rdchk(LO, m_c1[7:0], "c1 low");
        m_pre = 8'hFE;
        m_c0 = 8'hFE;
        apb(1'b1, INTC, 8'h02);
        apb(1'b1, C0V, m_pre);
        apb(1'b1, C0C, 8'h50);
        step0();
        rdchk(C0V, m_c0, "c0 count");
        step0();
        rdchk(C0V, m_c0, "c0 reload");
        rdchk(INTC, 8'h22, "c0 flag");
        chk("c0 irq", 1, c0_irq);
        m_pre = 8'h10;
        apb(1'b1, C0V, m_pre);
        rdchk(C0V, m_c0, "c0 running");
        step0();
        step0();
        rdchk(C0V, m_c0, "c0 new preload");
        rdchk(C0C, 8'h50, "c0 ctrl kept");
        chk("wakes", 2, wakes);
        apb(1'b1, INTC, 8'h00);
        apb(1'b1, LO, 8'hFF);
        apb(1'b1, HI, 8'hFF);
        apb(1'b1, C1C, 8'h58);
        pm.pulse(1, 8);
        rdchk(INTC, 8'h40, "c1 flag");
        chk("c1 irq masked", 0, c1_irq);
        start1(8'hD8);
        pm.pulse(1, 40);
        rdchk(C1C, 8'hC8, "pulse enable");
        win(16'd10, "pulse width");
        m_c1 = cnt;
        pm.pulse(1, 40);
        win(m_c1, "pulse held");
        for (int c = 0; c < 8; c++)
            run_timer(8'h90 | c[7:0], 16'd160 >> ((c > 4) ? 4 : c));
        run_timer(8'hB0, 16'd80);
        run_timer(8'h10, 16'd0);
        finish_test();
    end
endmodule
